/* File: fdm_cfg.svh */
// named constants for the frequency divider and input multiplexer front end
`ifndef FDM_CFG_SVH
`define FDM_CFG_SVH

// ****************************************************************
// register offsets (byte addresses on the apb)
// ****************************************************************
`define FDM_OFF_CTRL 12'h000
`define FDM_OFF_STATUS 12'h004
`define FDM_OFF_FREQ0 12'h020
`define FDM_OFF_FREQ_LAST 12'h03C

// ****************************************************************
// field layouts
// ****************************************************************
`define FDM_CTRL_SEL 2:0
`define FDM_CTRL_PPS 5:4
`define FDM_CTRL_RUN 8
`define FDM_STAT_SEL 2:0
`define FDM_STAT_STICKY 15:8
`define FDM_STAT_LIVE 23:16
`define FDM_STAT_PPS 27:24
`define FDM_FREQ_FIELD 23:0
`define FDM_FREQ_IDX 4:2
`define FDM_WORD_LANE 1:0
`define FDM_WORD_ALIGNED 2'h0

// ****************************************************************
// divider figures and reset values
// ****************************************************************
`define FDM_NCHAN 8
`define FDM_NPPS 4
`define FDM_PRESC_HZ 24'hE4_E1C0
`define FDM_PRESC_DIV 24'h00_000A
`define FDM_PRESC_LAST 4'h9
`define FDM_BYPASS_HZ 24'h00_0001
`define FDM_FREQ_RST 24'h00_0001
`define FDM_ONE24 24'h00_0001
`define FDM_ONE4 4'h1
`define FDM_ZERO32 32'h0000_0000

`endif

/* File: fdm_chan_div.sv */
// one frequency channel: optional divide-by-ten prescaler and 24-bit divider
`timescale 1ns/100ps
module fdm_chan_div
   import fdm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic in_lvl,
   input wire logic [23:0] nominal,
   output logic out
);

   // ****************************************************************
   // state and decode
   // ****************************************************************
   fdm_div_t q;
   fdm_div_t d;
   logic rise;          // rising edge of the input
   logic bypass;        // 1 hz input, no division
   logic presc;         // prescaler engaged
   logic [23:0] ratio;  // divider count target
   logic tick;          // edge counted by the divider
   logic last;          // divider at its final count

   // counting and gating
   always_comb begin
      d = q;
      d.prev = in_lvl;
      rise = in_lvl & ~q.prev;
      bypass = (nominal <= `FDM_BYPASS_HZ);
      presc = (nominal >= `FDM_PRESC_HZ);
      ratio = presc ? fdm_div10(nominal) : nominal;
      // >= rather than == recovers at once when software lowers n
      last = (q.dcnt >= 24'(ratio - `FDM_ONE24));
      tick = rise & (~presc | (q.pcnt == `FDM_PRESC_LAST));
      // prescaler counts every input edge while engaged
      if (rise && presc) begin
         d.pcnt = (q.pcnt == `FDM_PRESC_LAST) ? '0 : 4'(q.pcnt + `FDM_ONE4);
      end else if (!presc) begin
         d.pcnt = '0;
      end
      // divider blocks n-1 cycles and opens on the nth
      if (tick) begin
         d.dcnt = last ? '0 : 24'(q.dcnt + `FDM_ONE24);
         d.pass = last;
      end else if (rise) begin
         d.pass = 1'b0;
      end
      // bypass hands the pulse shape on untouched
      if (bypass) begin
         d.out = in_lvl;
      end else begin
         d.out = in_lvl & d.pass;
      end
   end

   // register the copy
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign out = q.out;

   // ****************************************************************
   // checks
   // ****************************************************************
   bypass_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
      bypass |=> (q.out == $past(in_lvl)))
      else $error("bypass output does not follow input");

   cycle_blocked_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!bypass && rise && !(tick && last)) |=> !q.out)
      else $error("blocked cycle reached the output");

   divider_step_a: assert property (@(posedge pclk) disable iff (!presetn)
      (tick && !last) |=> (q.dcnt == 24'($past(q.dcnt) + `FDM_ONE24)))
      else $error("divider count did not step by one");

   presc_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      (rise && presc && (q.pcnt != `FDM_PRESC_LAST)) |=> ($stable(q.dcnt) && !q.pass))
      else $error("prescaler let a non-tenth edge reach the divider");

endmodule : fdm_chan_div

/* File: fdm_pkg.sv */
// types shared by the divider channels and the front-end top
package fdm_pkg;
`include "fdm_cfg.svh"

   // ****************************************************************
   // apb carriers
   // ****************************************************************
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } fdm_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } fdm_apb_rsp_t;

   // ****************************************************************
   // state of one divider channel
   // ****************************************************************
   typedef struct packed {
      logic [3:0] pcnt;   // prescaler edge count
      logic [23:0] dcnt;  // divider edge count
      logic pass;         // current input cycle is let through
      logic prev;         // last sampled input level
      logic out;          // gated output
   } fdm_div_t;

   // ****************************************************************
   // state of the front-end top
   // ****************************************************************
   typedef struct packed {
      logic [7:0][23:0] freq;  // nominal frequency per channel, hertz
      logic [2:0] sel;         // selected frequency channel
      logic [1:0] pps;         // selected reference pulse
      logic run;               // outputs enabled
      logic blank;             // one-cycle gap after a channel switch
      logic start;             // to counter start input
      logic stop;              // to counter stop input
      logic [7:0] sticky;      // channel has passed a cycle
      logic [7:0] prev_out;    // channel outputs one cycle ago
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } fdm_top_t;

   // divider ratio after the fixed prescaler
   function automatic logic [23:0] fdm_div10(input logic [23:0] n);
      fdm_div10 = 24'(n / `FDM_PRESC_DIV);
   endfunction : fdm_div10

endpackage : fdm_pkg

/* File: fdm_sync.sv */
// two-flop synchroniser for the asynchronous frequency and pulse inputs
`timescale 1ns/100ps
module fdm_sync
   import fdm_pkg::*;
#(
   parameter int W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      logic [W-1:0] s1;  // metastable stage, read only by s2
      logic [W-1:0] s2;  // settled stage
   } fdm_sync_t;

   fdm_sync_t q;
   fdm_sync_t d;

   // shift both stages every edge
   always_comb begin
      d = q;
      d.s1 = async_in;
      d.s2 = q.s1;
   end

   // register the copy
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign sync_out = q.s2;

endmodule : fdm_sync

/* File: fdm_tic_model.sv */
// partner model: start and stop inputs of the time interval counter
`timescale 1ns/100ps
module fdm_tic_model #(
   parameter int MIN_GAP = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start_in,
   input wire logic stop_in,
   output logic [15:0] start_cnt,
   output logic [15:0] stop_cnt,
   output logic [15:0] rate_viol
);
   // ****************************************************************
   // event capture
   // ****************************************************************
   logic start_q; // start level one cycle ago
   logic stop_q; // stop level one cycle ago
   logic [15:0] gap_q; // cycles since last start event, saturating

   // counts rising edges; a start closer than min_gap to the last is a
   // dead-time loss on the real counter, so it is flagged, not dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_q <= 1'b0;
         stop_q <= 1'b0;
         gap_q <= 16'hFFFF;
         start_cnt <= 16'h0000;
         stop_cnt <= 16'h0000;
         rate_viol <= 16'h0000;
      end else begin
         start_q <= start_in;
         stop_q <= stop_in;
         gap_q <= (gap_q == 16'hFFFF) ? gap_q : gap_q + 16'h0001;
         if (start_in && !start_q) begin
            start_cnt <= start_cnt + 16'h0001;
            gap_q <= 16'h0001;
            if (gap_q < 16'(MIN_GAP)) begin
               rate_viol <= rate_viol + 16'h0001;
            end
         end
         if (stop_in && !stop_q) begin
            stop_cnt <= stop_cnt + 16'h0001;
         end
      end
   end
endmodule : fdm_tic_model

/* File: fdm_top.sv */
// front end of the counter card: eight divided inputs and four reference pulses
//
// Behaviour
// - divider blocks n-1 cycles, passes nth
// - divider counter is 24 bits wide
// - prescaler on at 15 MHz or above
// - chain delivers 1 Hz for nominals below 15 MHz, and above only at multiples of ten
// - 1 Hz input bypasses divider unaltered
// - multiplexer picks one of eight inputs
// - each input has own 24-bit divider
// - multiplexer switches on new channel choice
// - second multiplexer picks one of four pps
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
module fdm_top
   import fdm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire fdm_apb_req_t apb_req,
   output fdm_apb_rsp_t apb_rsp,
   input wire logic [7:0] freq_in,
   input wire logic [3:0] pps_in,
   output logic counter_start,
   output logic counter_stop
);

   // ****************************************************************
   // reset image
   // ****************************************************************
   // every channel starts in bypass so nothing is divided by zero
   localparam fdm_top_t TOP_RST = '{
      freq: {`FDM_NCHAN{`FDM_FREQ_RST}},
      default: '0
   };

   // ****************************************************************
   // declarations
   // ****************************************************************
   fdm_top_t q;               // all registered state
   fdm_top_t d;               // next state
   logic [11:0] sync_all;     // settled copies of all pins
   logic [7:0] freq_lvl;      // settled frequency inputs
   logic [3:0] pps_lvl;       // settled reference pulses
   logic [7:0] ch_out;        // divided channel outputs
   logic [7:0] fired;         // channel output rose this cycle
   logic setup;               // apb setup phase
   logic commit;              // apb access completes
   logic [11:0] addr;         // request address
   logic [31:0] wdata;        // request write data
   logic [2:0] widx;          // frequency register index

   // all checks below run on the bus clock and sleep in reset
   default clocking chk_clk @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // ****************************************************************
   // address decode
   // ****************************************************************
   // true when the word address belongs to the map
   function automatic logic map_hit(input logic [11:0] a);
      if (a[`FDM_WORD_LANE] != `FDM_WORD_ALIGNED) begin
         map_hit = 1'b0;
      end else if (a == `FDM_OFF_CTRL) begin
         map_hit = 1'b1;
      end else if (a == `FDM_OFF_STATUS) begin
         map_hit = 1'b1;
      end else if ((a >= `FDM_OFF_FREQ0) && (a <= `FDM_OFF_FREQ_LAST)) begin
         map_hit = 1'b1;
      end else begin
         map_hit = 1'b0;
      end
   endfunction : map_hit

   // read value of the word at an address; unmapped words read zero
   function automatic logic [31:0] read_word(
      input logic [11:0] a,
      input fdm_top_t s,
      input logic [7:0] live,
      input logic [3:0] plive
   );
      logic [31:0] r;
      r = `FDM_ZERO32;
      if (!map_hit(a)) begin
         r = `FDM_ZERO32;
      end else if (a == `FDM_OFF_CTRL) begin
         r[`FDM_CTRL_SEL] = s.sel;
         r[`FDM_CTRL_PPS] = s.pps;
         r[`FDM_CTRL_RUN] = s.run;
      end else if (a == `FDM_OFF_STATUS) begin
         r[`FDM_STAT_SEL] = s.sel;
         r[`FDM_STAT_STICKY] = s.sticky;
         r[`FDM_STAT_LIVE] = live;
         r[`FDM_STAT_PPS] = plive;
      end else begin
         r[`FDM_FREQ_FIELD] = s.freq[a[`FDM_FREQ_IDX]];
      end
      read_word = r;
   endfunction : read_word

   // ****************************************************************
   // input synchronisers
   // ****************************************************************
   // pins come from foreign clocks; two flops before any logic
   fdm_sync #(
      .W(12)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({pps_in, freq_in}),
      .sync_out(sync_all)
   );

   assign freq_lvl = sync_all[7:0];
   assign pps_lvl = sync_all[11:8];

   // ****************************************************************
   // divider channels
   // ****************************************************************
   // one independent prescaler and divider per input
   for (genvar gi = 0; gi < `FDM_NCHAN; gi++) begin : g_chan
      fdm_chan_div u_div (
         .pclk(pclk),
         .presetn(presetn),
         .in_lvl(freq_lvl[gi]),
         .nominal(q.freq[gi]),
         .out(ch_out[gi])
      );
   end

   // ****************************************************************
   // bus slave, selection and output multiplexers
   // ****************************************************************
   assign addr = apb_req.paddr;
   assign wdata = apb_req.pwdata;
   assign widx = apb_req.paddr[`FDM_FREQ_IDX];

   // one process fills the whole next state
   always_comb begin
      d = q;
      d.pready = 1'b0;
      d.pslverr = 1'b0;
      d.blank = 1'b0;
      setup = apb_req.psel & ~apb_req.penable;
      commit = apb_req.psel & apb_req.penable & q.pready;
      fired = ch_out & ~q.prev_out;
      d.prev_out = ch_out;
      // answer is prepared in setup so prdata leaves a flop
      if (setup) begin
         d.pready = 1'b1;
         d.pslverr = ~map_hit(addr);
         d.prdata = read_word(addr, q, freq_lvl, pps_lvl);
      end
      // writes land only on the completing access edge
      if (commit && apb_req.pwrite && map_hit(addr)) begin
         if (addr == `FDM_OFF_CTRL) begin
            d.sel = wdata[`FDM_CTRL_SEL];
            d.pps = wdata[`FDM_CTRL_PPS];
            d.run = wdata[`FDM_CTRL_RUN];
         end else if (addr == `FDM_OFF_STATUS) begin
            // write one to clear the seen bits
            d.sticky = q.sticky & ~wdata[`FDM_STAT_STICKY];
         end else begin
            d.freq[widx] = wdata[`FDM_FREQ_FIELD];
         end
      end
      // a fresh event outweighs a clear in the same cycle
      d.sticky = d.sticky | fired;
      // gap one cycle on a switch so no runt edge from the old input
      d.blank = (d.sel != q.sel);
      // start side follows the chosen divided channel
      d.start = q.run & ~q.blank & ch_out[q.sel];
      // stop side follows the chosen reference pulse
      d.stop = q.run & pps_lvl[q.pps];
   end

   // register the copy
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= TOP_RST;
      end else begin
         q <= d;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   // all straight from flops
   assign apb_rsp.prdata = q.prdata;
   assign apb_rsp.pready = q.pready;
   assign apb_rsp.pslverr = q.pslverr;
   assign counter_start = q.start;
   assign counter_stop = q.stop;

   // ****************************************************************
   // checks
   // ****************************************************************
   // start side copies the chosen channel
   start_mux_a: assert property (@(posedge pclk) disable iff (!presetn)
      (q.run && !q.blank) |=> (q.start == $past(ch_out[q.sel])))
      else $error("start output is not the selected channel");

   // stop side copies the chosen reference
   pps_mux_a: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> (q.stop == ($past(q.run) & $past(pps_lvl[q.pps]))))
      else $error("stop output is not the selected reference");

   // a new selection raises the gap flag
   switch_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
      $changed(q.sel) |-> q.blank)
      else $error("channel switch not flagged");

   // the gap keeps the start side low
   switch_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
      q.blank |=> !q.start)
      else $error("start output not gapped after switch");

   // control write sets the selection
   sel_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      (commit && apb_req.pwrite && (addr == `FDM_OFF_CTRL)) |=> (q.sel == $past(wdata[`FDM_CTRL_SEL])))
      else $error("channel selection did not take the written value");

   // one access cycle, never a wait state
   bus_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
      setup |=> (q.pready ##1 !q.pready))
      else $error("apb answer not exactly one cycle after setup");

   // an event beats a clear in the same cycle
   seen_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
      (|fired) |=> ((q.sticky & $past(fired)) == $past(fired)))
      else $error("channel event lost against a clear");

   // ****************************************************************
   // bus and state checks
   // ****************************************************************
   // stopped front end keeps both sides low
   run_gate_a: assert property (
      !q.run |=> (!q.start && !q.stop))
      else $error("output active while stopped");

   // ready is a single-cycle pulse
   pready_pulse_a: assert property (
      q.pready |=> !q.pready)
      else $error("ready held too long");

   // unmapped words answer with an error and read zero
   bad_addr_a: assert property (
      (setup && !map_hit(addr)) |=> (q.pslverr && (q.prdata == `FDM_ZERO32)))
      else $error("unmapped access not refused");

   // mapped words never raise an error
   good_addr_a: assert property (
      (setup && map_hit(addr)) |=> !q.pslverr)
      else $error("mapped access refused");

   // error only ever rides on ready
   err_with_ready_a: assert property (
      q.pslverr |-> q.pready)
      else $error("error without ready");

   // read data only moves on a setup cycle
   prdata_hold_a: assert property (
      !setup |=> $stable(q.prdata))
      else $error("read data moved outside setup");

   // nominal write lands in the addressed channel
   freq_write_a: assert property (
      (commit && apb_req.pwrite && map_hit(addr) && (addr >= `FDM_OFF_FREQ0))
      |=> (q.freq[$past(widx)] == $past(wdata[`FDM_FREQ_FIELD])))
      else $error("nominal write lost");

   // nominal read returns the addressed channel
   freq_read_a: assert property (
      (setup && map_hit(addr) && (addr >= `FDM_OFF_FREQ0))
      |=> (q.prdata[`FDM_FREQ_FIELD] == $past(q.freq[widx])))
      else $error("nominal read wrong");

   // control read mirrors selection and run
   ctrl_read_a: assert property (
      (setup && (addr == `FDM_OFF_CTRL))
      |=> ((q.prdata[`FDM_CTRL_SEL] == $past(q.sel)) && (q.prdata[`FDM_CTRL_RUN] == $past(q.run))))
      else $error("control read wrong");

   // refused writes leave the configuration alone
   bad_write_a: assert property (
      (commit && apb_req.pwrite && !map_hit(addr)) |=> ($stable(q.freq) && $stable(q.sel) && $stable(q.run)))
      else $error("refused write changed state");

   // no gap without a switch
   blank_cause_a: assert property (
      $stable(q.sel) |-> !q.blank)
      else $error("gap without a switch");

   // the gap lasts one cycle per switch
   blank_once_a: assert property (
      q.blank |=> (!q.blank || $changed(q.sel)))
      else $error("gap longer than one cycle");

   // seen bits only move on an event or a clear
   sticky_hold_a: assert property (
      (!(|fired) && !(commit && apb_req.pwrite && (addr == `FDM_OFF_STATUS))) |=> $stable(q.sticky))
      else $error("seen bits moved by themselves");

   // a clear with no event drops the written bits
   sticky_clear_a: assert property (
      (commit && apb_req.pwrite && (addr == `FDM_OFF_STATUS) && !(|fired))
      |=> ((q.sticky & $past(wdata[`FDM_STAT_STICKY])) == 8'h00))
      else $error("seen bits not cleared");

endmodule : fdm_top

/* File: tb_freq_divider_input_mux.sv */
// self-checking bench for the divider and multiplexer front end
`timescale 1ns/100ps
`include "fdm_cfg.svh"
module tb_freq_divider_input_mux
   import fdm_pkg::*;
;
   // ****************************************************************
   // signals
   // ****************************************************************
   logic pclk; // 100 mhz bench clock
   logic presetn; // active-low reset
   fdm_apb_req_t apb_req; // apb request bundle
   fdm_apb_rsp_t apb_rsp; // apb response bundle
   logic [7:0] freq_in; // frequency inputs
   logic [3:0] pps_in; // reference pulse inputs
   logic counter_start;
   logic counter_stop;
   logic [15:0] start_cnt;
   logic [15:0] stop_cnt;
   logic [15:0] rate_viol;
   logic [31:0] rd; // last read data
   logic err; // last slave error
   int failures;
   int n_tests;
   int i;
   int s0;

   fdm_top fdm_top_i (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
      .freq_in(freq_in), .pps_in(pps_in), .counter_start(counter_start), .counter_stop(counter_stop));

   fdm_tic_model #(.MIN_GAP(8)) fdm_tic_model_i (.pclk(pclk), .presetn(presetn),
      .start_in(counter_start), .stop_in(counter_stop), .start_cnt(start_cnt),
      .stop_cnt(stop_cnt), .rate_viol(rate_viol));

   // free-running clock
   always #5 pclk = ~pclk;

   // ****************************************************************
   // tasks
   // ****************************************************************
   task automatic end_of_test;
      $display("failures=%0d n_tests=%0d", failures, n_tests);
      if (failures == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_of_test

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // one apb transfer; waits on pready under a bound, never a fixed count
   task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int k;
      @(posedge pclk);
      apb_req.psel <= 1'b1;
      apb_req.penable <= 1'b0;
      apb_req.pwrite <= wr;
      apb_req.paddr <= a;
      apb_req.pwdata <= wd;
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge pclk);
         if (apb_rsp.pready === 1'b1) begin
            break;
         end
      end
      if (k == 20) begin
         failures++;
         $display("Error at %0t: no pready", $time);
         end_of_test();
      end
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask : apb_xfer

   function automatic logic [31:0] ctrl(input int sel, input int pps, input logic run);
      ctrl = {23'h00_0000, run, 2'h0, 2'(pps), 1'b0, 3'(sel)};
   endfunction : ctrl

   // cnt input cycles of period 8, all masked lines in step
   task automatic pulse(input logic [7:0] fm, input logic [3:0] pm, input int cnt);
      repeat (cnt) begin
         @(posedge pclk);
         freq_in <= fm;
         pps_in <= pm;
         repeat (4) @(posedge pclk);
         freq_in <= 8'h00;
         pps_in <= 4'h0;
         repeat (3) @(posedge pclk);
      end
      repeat (10) @(posedge pclk);
   endtask : pulse

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      apb_req = '0;
      freq_in = 8'h00;
      pps_in = 4'h0;
      failures = 0;
      n_tests = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      // reset values: everything idle, every channel in bypass
      apb_xfer(1'b0, `FDM_OFF_CTRL, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      for (i = 0; i < 8; i++) begin
         apb_xfer(1'b0, `FDM_OFF_FREQ0 + 12'(4 * i), 32'h0000_0000);
         check(rd, 32'h0000_0001);
      end
      // refused accesses: unmapped and unaligned
      apb_xfer(1'b1, 12'h100, 32'hFFFF_FFFF);
      check({31'h0000_0000, err}, 32'h0000_0001);
      apb_xfer(1'b0, 12'h021, 32'h0000_0000);
      check({rd[30:0], err}, 32'h0000_0001);
      // divider field holds exactly 24 bits
      apb_xfer(1'b1, `FDM_OFF_FREQ_LAST, 32'hFFFF_FFFF);
      apb_xfer(1'b0, `FDM_OFF_FREQ_LAST, 32'h0000_0000);
      check(rd, 32'h00FF_FFFF);
      // each reference pulse source routed alone to the stop input
      for (i = 0; i < 4; i++) begin
         apb_xfer(1'b1, `FDM_OFF_CTRL, ctrl(0, i, 1'b1));
         s0 = int'(stop_cnt);
         pulse(8'h00, ~(4'h1 << i), 2);
         pulse(8'h00, 4'h1 << i, 3);
         check(32'(int'(stop_cnt) - s0), 32'h0000_0003);
      end
      // channel i divides by i+1; its neighbour runs too but stays unrouted
      for (i = 0; i < 8; i++) begin
         apb_xfer(1'b1, `FDM_OFF_FREQ0 + 12'(4 * i), 32'(i + 1));
      end
      for (i = 0; i < 8; i++) begin
         apb_xfer(1'b1, `FDM_OFF_CTRL, ctrl(i, 0, 1'b1));
         apb_xfer(1'b0, `FDM_OFF_STATUS, 32'h0000_0000);
         check({29'h0000_0000, rd[2:0]}, 32'(i));
         s0 = int'(start_cnt);
         pulse((8'h01 << i) | (8'h01 << ((i + 1) % 8)), 4'h0, 2 * (i + 1));
         check(32'(int'(start_cnt) - s0), 32'h0000_0002);
      end
      // every channel has passed a cycle; flags clear on write of ones
      apb_xfer(1'b0, `FDM_OFF_STATUS, 32'h0000_0000);
      check({24'h00_0000, rd[15:8]}, 32'h0000_00FF);
      apb_xfer(1'b1, `FDM_OFF_STATUS, 32'h0000_FF00);
      apb_xfer(1'b0, `FDM_OFF_STATUS, 32'h0000_0000);
      check({24'h00_0000, rd[15:8]}, 32'h0000_0000);
      // fresh ratio of 5: four cycles blocked, the fifth passes
      apb_xfer(1'b1, `FDM_OFF_FREQ0 + 12'h008, 32'h0000_0005);
      apb_xfer(1'b1, `FDM_OFF_CTRL, ctrl(2, 1, 1'b1));
      // a write does not clear the count: one edge is left from ratio 3
      s0 = int'(start_cnt);
      pulse(8'h04, 4'h0, 3);
      check(32'(int'(start_cnt) - s0), 32'h0000_0000);
      pulse(8'h04, 4'h0, 1);
      check(32'(int'(start_cnt) - s0), 32'h0000_0001);
      pulse(8'h04, 4'h0, 4);
      check(32'(int'(start_cnt) - s0), 32'h0000_0001);
      pulse(8'h04, 4'h0, 1);
      check(32'(int'(start_cnt) - s0), 32'h0000_0002);
      // at 15 mhz ten input edges make one divider count
      apb_xfer(1'b1, `FDM_OFF_FREQ0 + 12'h00C, 32'h00E4_E1C0);
      apb_xfer(1'b1, `FDM_OFF_CTRL, ctrl(3, 1, 1'b1));
      s0 = int'(start_cnt);
      pulse(8'h08, 4'h0, 20);
      check(32'(int'(start_cnt) - s0), 32'h0000_0000);
      // outputs held low while not running
      apb_xfer(1'b1, `FDM_OFF_CTRL, ctrl(2, 1, 1'b0));
      s0 = int'(start_cnt) + int'(stop_cnt);
      pulse(8'h04, 4'h2, 10);
      check(32'(int'(start_cnt) + int'(stop_cnt) - s0), 32'h0000_0000);
      check({16'h0000, rate_viol}, 32'h0000_0000);
      // status shows the settled pin levels live
      freq_in <= 8'hA5;
      pps_in <= 4'h6;
      repeat (3) @(posedge pclk);
      apb_xfer(1'b0, `FDM_OFF_STATUS, 32'h0000_0000);
      check({20'h0_0000, rd[27:16]}, 32'h0000_06A5);
      end_of_test();
   end

   // hang guard
   initial begin
      repeat (100000) @(posedge pclk);
      failures++;
      $display("Error at %0t: run too long", $time);
      end_of_test();
   end
endmodule : tb_freq_divider_input_mux
